// File: verilog/cma_pkg.sv
// Package of constants and types for the core memory addressing block
package cma_pkg;
    // Word layout
    localparam int DATA_W       = 16;
    localparam int WORD_W       = 17;
    localparam int PARITY_BIT   = 16;
    localparam int ADDR_W       = 15;
    // Full address word fields
    localparam int IND_BIT      = 15;
    localparam int STACK_HI     = 14;
    localparam int STACK_LO     = 13;
    localparam int MODULE_BIT   = 12;
    localparam int PAGE_HI      = 12;
    localparam int PAGE_LO      = 10;
    localparam int OFFS_HI      = 9;
    localparam int OFFS_W       = 10;
    // Instruction word fields
    localparam int OPC_HI       = 14;
    localparam int OPC_LO       = 11;
    localparam int ZC_BIT       = 10;
    // Stack sizes and page size
    localparam int SMALL_STACK  = 4096;
    localparam int LARGE_STACK  = 8192;
    localparam int MODULE_WORDS = 4096;
    localparam int PAGE_WORDS   = 1024;
    // Accumulator aliases
    localparam logic [14:0] ACC_A_ADDR = 15'h0000;
    localparam logic [14:0] ACC_B_ADDR = 15'h0001;
    // Read purposes
    typedef enum logic [1:0]
    {
        CMA_RD_DISPLAY = 2'b00,
        CMA_RD_FETCH   = 2'b01,
        CMA_RD_OPERAND = 2'b10,
        CMA_RD_INDIR   = 2'b11
    } cma_purpose_type;
    // Read sequencer states
    typedef enum logic [2:0]
    {
        CMA_IDLE    = 3'b000,
        CMA_LOAD    = 3'b001,
        CMA_ACCESS  = 3'b010,
        CMA_CAPTURE = 3'b011,
        CMA_RESTORE = 3'b100,
        CMA_DONE    = 3'b101
    } cma_state_type;
endpackage : cma_pkg

// File: verilog/cma_decode.sv
// Full address word decoder: stack, module, page, offset, accumulator alias
`timescale 1ns/100ps
module cma_decode
(
    input  wire logic [14:0] addr_i,
    output logic      [1:0]  stack_o,
    output logic             upper_o,
    output logic      [2:0]  page_o,
    output logic      [9:0]  offset_o,
    output logic             acc_sel_o,
    output logic             acc_b_o
);
    // Field split of the address
    always_comb
    begin
        stack_o   = addr_i[cma_pkg::STACK_HI:cma_pkg::STACK_LO];
        upper_o   = addr_i[cma_pkg::MODULE_BIT];
        page_o    = addr_i[cma_pkg::PAGE_HI:cma_pkg::PAGE_LO];
        offset_o  = addr_i[cma_pkg::OFFS_HI:0];
        acc_sel_o = (addr_i == cma_pkg::ACC_A_ADDR) ||
                    (addr_i == cma_pkg::ACC_B_ADDR);
        acc_b_o   = (addr_i == cma_pkg::ACC_B_ADDR);
    end
endmodule : cma_decode

// File: verilog/cma_parity.sv
// Odd parity generator over a data word
`timescale 1ns/100ps
module cma_parity
#(
    parameter int WIDTH = 16
)
(
    input  wire logic [WIDTH-1:0] data_i,
    output logic                  parity_o
);
    // Parity bit that makes the count of ones odd
    assign parity_o = ~(^data_i);
endmodule : cma_parity

// File: verilog/cma_core.sv
// Core memory addressing and read/restore sequencer
`timescale 1ns/100ps
// How it works
// - Each stored word is 17 bits: 16 data bits and a parity bit at bit 16.
// - A stack holds 4096 or 8192 words, chosen by a parameter.
// - Words group into 4K modules; a large stack has lower and upper modules by address.
// - Addresses 0 and 1 select accumulators A and B, never core.
// - Each module holds four pages of 1024 words.
// - Full address: bit 15 indirect, 14..13 stack, 12..10 page, 9..0 offset.
// - Instruction: bit 15 indirect, 14..11 opcode, bit 10 page select, 9..0 offset.
// - Direct with page bit set uses the instruction's own page.
// - Direct with page bit clear uses page 0 of the first stack.
// - Indirect reads a pointer word; bit 15 clear gives a 15-bit operand address.
// - A pointer with bit 15 set is followed again until one has bit 15 clear.
// - Each read loads the address register from the first scratch pad, or from the instruction when form_ea_i is set, and captures data.
// - One read sequence serves display, instruction fetch and operand fetch.
// - After readout the word is written back at the same address from the captured data.
// - Only a word read in the fetch phase is flagged as an instruction.
module cma_core
#(
    parameter int STACK_WORDS = cma_pkg::LARGE_STACK,
    parameter int NUM_STACKS  = 4
)
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic        start_i,
    input  wire logic [1:0]  purpose_i,
    input  wire logic [15:0] first_scratch_pad_i,
    input  wire logic [15:0] instr_i,
    input  wire logic [14:0] instr_addr_i,
    input  wire logic        form_ea_i,
    input  wire logic [15:0] acc_a_i,
    input  wire logic [15:0] acc_b_i,
    output logic      [14:0] mem_addr_o,
    output logic      [15:0] read_data_o,
    output logic             busy_o,
    output logic             done_o,
    output logic             is_instr_o,
    output logic             parity_err_o,
    output logic             acc_hit_o,
    output logic      [14:0] ea_o,
    output logic             ea_valid_o,
    output logic             bad_addr_o
);
    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    localparam int DEPTH = STACK_WORDS * NUM_STACKS;
    localparam int AW    = $clog2(DEPTH);
    localparam int NMOD  = DEPTH / cma_pkg::MODULE_WORDS;

    cma_pkg::cma_state_type   state_r;
    cma_pkg::cma_purpose_type purpose_r;
    logic [cma_pkg::WORD_W-1:0] core_mem [DEPTH];
    logic [14:0]  mar_r;
    logic [15:0]  rdr_r;
    logic [16:0]  sense_r;
    logic         busy_r;
    logic         done_r;
    logic         is_instr_r;
    logic         perr_r;
    logic         acc_hit_r;
    logic [14:0]  ea_r;
    logic         ea_valid_r;
    logic         bad_r;
    logic         chain_r;
    logic [14:0]  load_addr;
    logic [1:0]   dec_stack;
    logic         dec_upper;
    logic [2:0]   dec_page;
    logic [9:0]   dec_offset;
    logic         dec_acc;
    logic         dec_acc_b;
    logic         gen_par;
    logic         chk_par;
    logic [15:0]  acc_word;
    logic         in_range;
    logic [AW-1:0] core_index;
    logic         take;
    logic         seq_end;

    ////////////////////////////////////////////////////////////////////////////
    // Direct effective address from an instruction word
    function automatic logic [14:0] cma_direct_ea(input logic [15:0] iw,
                                                  input logic [14:0] loc);
        logic [14:0] ea;
        ea = 15'h0000;
        if (iw[cma_pkg::ZC_BIT])
            ea = {loc[14:10], iw[cma_pkg::OFFS_HI:0]};
        else
            ea = {5'h00, iw[cma_pkg::OFFS_HI:0]};
        return ea;
    endfunction : cma_direct_ea

    // A memory-reference instruction with its indirect flag set asks for a pointer
    function automatic logic cma_ind_req(input logic        form,
                                         input logic [15:0] iw);
        return form && iw[cma_pkg::IND_BIT];
    endfunction : cma_ind_req

    ////////////////////////////////////////////////////////////////////////////
    // Address decode and parity helpers
    cma_decode u_decode
    (
        .addr_i    (mar_r),
        .stack_o   (dec_stack),
        .upper_o   (dec_upper),
        .page_o    (dec_page),
        .offset_o  (dec_offset),
        .acc_sel_o (dec_acc),
        .acc_b_o   (dec_acc_b)
    );

    cma_parity #(.WIDTH(cma_pkg::DATA_W)) u_par_gen
    (
        .data_i   (rdr_r),
        .parity_o (gen_par)
    );

    cma_parity #(.WIDTH(cma_pkg::DATA_W)) u_par_chk
    (
        .data_i   (sense_r[15:0]),
        .parity_o (chk_par)
    );

    // Source of the address register: instruction direct address or scratch pad
    always_comb
    begin
        if (form_ea_i)
            load_addr = cma_direct_ea(instr_i, instr_addr_i);
        else
            load_addr = first_scratch_pad_i[14:0];
    end

    // Installed range: stacks are contiguous 4K modules from address 0
    assign in_range   = ({1'b0, dec_stack, dec_upper} < 4'(NMOD));
    // Core word index rebuilt from the decoded stack, page and offset
    assign core_index = AW'({dec_stack, dec_page, dec_offset});
    assign acc_word   = dec_acc_b ? acc_b_i : acc_a_i;
    // Request taken this cycle, and last cycle of a sequence
    assign take       = start_i && (state_r == cma_pkg::CMA_IDLE);
    assign seq_end    = (state_r == cma_pkg::CMA_DONE);

    ////////////////////////////////////////////////////////////////////////////
    // Read / restore sequencer
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_r    <= cma_pkg::CMA_IDLE;
            purpose_r  <= cma_pkg::CMA_RD_DISPLAY;
            mar_r      <= 15'h0000;
            busy_r     <= 1'b0;
            chain_r    <= 1'b0;
        end
        else
        begin
            unique case (state_r)
                cma_pkg::CMA_IDLE:
                begin
                    if (start_i)
                    begin
                        mar_r   <= load_addr;
                        chain_r <= cma_ind_req(form_ea_i, instr_i);
                        if (cma_ind_req(form_ea_i, instr_i))
                            purpose_r <= cma_pkg::CMA_RD_INDIR;
                        else
                            purpose_r <= cma_pkg::cma_purpose_type'(purpose_i);
                        busy_r  <= 1'b1;
                        state_r <= cma_pkg::CMA_LOAD;
                    end
                end
                cma_pkg::CMA_LOAD:    state_r <= cma_pkg::CMA_ACCESS;
                cma_pkg::CMA_ACCESS:  state_r <= cma_pkg::CMA_CAPTURE;
                cma_pkg::CMA_CAPTURE:
                begin
                    // Accumulator aliases have no core word to restore; an
                    // accumulator met as a pointer may still carry the chain on
                    if (dec_acc && chain_r && acc_word[cma_pkg::IND_BIT])
                    begin
                        mar_r   <= acc_word[14:0];
                        state_r <= cma_pkg::CMA_LOAD;
                    end
                    else
                        state_r <= dec_acc ? cma_pkg::CMA_DONE : cma_pkg::CMA_RESTORE;
                end
                cma_pkg::CMA_RESTORE:
                begin
                    // Pointer words keep the chain going until bit 15 is clear
                    if (chain_r && rdr_r[cma_pkg::IND_BIT])
                    begin
                        mar_r   <= rdr_r[14:0];
                        state_r <= cma_pkg::CMA_LOAD;
                    end
                    else
                        state_r <= cma_pkg::CMA_DONE;
                end
                cma_pkg::CMA_DONE:
                begin
                    busy_r  <= 1'b0;
                    chain_r <= 1'b0;
                    state_r <= cma_pkg::CMA_IDLE;
                end
                default:
                    state_r <= cma_pkg::CMA_IDLE;
            endcase
        end
    end

    // Core array: destructive sense then rewrite, no reset on storage
    always_ff @(posedge sys_clk_i)
    begin
        if (state_r == cma_pkg::CMA_ACCESS && !dec_acc && in_range)
        begin
            sense_r <= core_mem[core_index];
            core_mem[core_index] <= '0;
        end
        else if (state_r == cma_pkg::CMA_RESTORE && !dec_acc && in_range)
            core_mem[core_index] <= {gen_par, rdr_r};
        else if (state_r == cma_pkg::CMA_ACCESS)
            sense_r <= '0;
    end

    // Read data register capture
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdr_r     <= 16'h0000;
            perr_r    <= 1'b0;
            acc_hit_r <= 1'b0;
            bad_r     <= 1'b0;
        end
        else if (state_r == cma_pkg::CMA_CAPTURE)
        begin
            acc_hit_r <= dec_acc;
            bad_r     <= !dec_acc && !in_range;
            if (dec_acc)
            begin
                rdr_r  <= acc_word;
                perr_r <= 1'b0;
            end
            else
            begin
                rdr_r  <= sense_r[15:0];
                perr_r <= in_range && (sense_r[cma_pkg::PARITY_BIT] != chk_par);
            end
        end
    end

    // Completion pulse, one cycle after the sequence ends
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            done_r <= 1'b0;
        else
            done_r <= seq_end;
    end

    // Instruction tag, refreshed only when a sequence ends
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            is_instr_r <= 1'b0;
        else if (seq_end)
            is_instr_r <= (purpose_r == cma_pkg::CMA_RD_FETCH);
    end

    // Effective address: direct at the take, end of a pointer chain otherwise
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ea_r       <= 15'h0000;
            ea_valid_r <= 1'b0;
        end
        else
        begin
            ea_valid_r <= 1'b0;
            if (take && form_ea_i && !cma_ind_req(form_ea_i, instr_i))
            begin
                ea_r       <= cma_direct_ea(instr_i, instr_addr_i);
                ea_valid_r <= 1'b1;
            end
            else if (seq_end && purpose_r == cma_pkg::CMA_RD_INDIR)
            begin
                // The word that ended the chain has bit 15 clear
                ea_r       <= rdr_r[14:0];
                ea_valid_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign mem_addr_o   = mar_r;
    assign read_data_o  = rdr_r;
    assign busy_o       = busy_r;
    assign done_o       = done_r;
    assign is_instr_o   = is_instr_r;
    assign parity_err_o = perr_r;
    assign acc_hit_o    = acc_hit_r;
    assign ea_o         = ea_r;
    assign ea_valid_o   = ea_valid_r;
    assign bad_addr_o   = bad_r;
endmodule : cma_core

// File: tb/cma_core_monitor.sv
// Assertion checker for the core memory addressing block
`timescale 1ns/100ps
module cma_core_monitor
#(
    parameter int STACK_WORDS = 8192,
    parameter int NUM_STACKS  = 4
)
(
    input wire logic        sys_clk_i,
    input wire logic        rst_i,
    input wire logic        start_i,
    input wire logic [1:0]  purpose_i,
    input wire logic [15:0] first_scratch_pad_i,
    input wire logic [15:0] instr_i,
    input wire logic [14:0] instr_addr_i,
    input wire logic        form_ea_i,
    input wire logic [15:0] acc_a_i,
    input wire logic [14:0] mem_addr_o,
    input wire logic [15:0] read_data_o,
    input wire logic        busy_o,
    input wire logic        done_o,
    input wire logic        is_instr_o,
    input wire logic        acc_hit_o,
    input wire logic [14:0] ea_o,
    input wire logic        ea_valid_o,
    input wire logic        bad_addr_o
);
    localparam int DEPTH = STACK_WORDS * NUM_STACKS;
    logic [1:0] pur_r;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff rst_i;
    // Purpose held from the edge that takes a request
    always_ff @(posedge sys_clk_i or posedge rst_i)
        if (rst_i)
            pur_r <= 2'h0;
        else if (start_i && !busy_o)
            pur_r <= purpose_i;
    ////////////////////////////////////////////////////////////////////////////////
    // Request takes
    sequence take_s;
        start_i && !busy_o;
    endsequence
    sequence scr_take_s;
        take_s ##0 !form_ea_i;
    endsequence
    sequence ea_take_s;
        take_s ##0 form_ea_i && !instr_i[15];
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    done_pulse_a: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    done_time_a: assert property (scr_take_s |-> ##[5:6] done_o)
        else $error("read did not finish in time");
    busy_hold_a: assert property (take_s |=> busy_o [*4])
        else $error("busy dropped during a read");
    addr_load_a: assert property (scr_take_s |=>
        {1'b0, mem_addr_o} == ($past(first_scratch_pad_i) & 16'h7FFF))
        else $error("address register not loaded from scratch pad");
    instr_flag_a: assert property (done_o |-> is_instr_o == (pur_r == 2'h1))
        else $error("instruction flag wrong");
    acc_alias_a: assert property (done_o && acc_hit_o && mem_addr_o == 15'h0000
        |-> read_data_o == acc_a_i)
        else $error("address zero did not return accumulator A");
    page_zero_a: assert property (ea_take_s ##0 !instr_i[10] |=> ea_valid_o
        && {1'b0, ea_o} == ($past(instr_i) & 16'h03FF))
        else $error("page zero address wrong");
    cur_page_a: assert property (ea_take_s ##0 instr_i[10] |=> ea_valid_o
        && (ea_o & 15'h7C00) == ($past(instr_addr_i) & 15'h7C00))
        else $error("current page address wrong");
    bad_addr_a: assert property (done_o |-> bad_addr_o == (mem_addr_o >= DEPTH))
        else $error("installed depth flag wrong");
endmodule : cma_core_monitor
bind cma_core cma_core_monitor #(.STACK_WORDS(STACK_WORDS), .NUM_STACKS(NUM_STACKS)) mon
(
    .sys_clk_i, .rst_i, .start_i, .purpose_i, .first_scratch_pad_i, .instr_i,
    .instr_addr_i, .form_ea_i, .acc_a_i, .mem_addr_o, .read_data_o, .busy_o,
    .done_o, .is_instr_o, .acc_hit_o, .ea_o, .ea_valid_o, .bad_addr_o
);

// File: tb/cma_proc_model.sv
// Processor-side model holding the two accumulators
`timescale 1ns/100ps
module cma_proc_model
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic [15:0] seed_i,
    output logic      [15:0] acc_a_o,
    output logic      [15:0] acc_b_o
);
    // Accumulators load at reset and then hold for the whole run
    always_ff @(posedge sys_clk_i or posedge rst_i)
        if (rst_i)
        begin
            acc_a_o <= seed_i;
            acc_b_o <= ~seed_i;
        end
endmodule : cma_proc_model

// File: tb/cma_core_test.sv
// Self-checking testbench for the core memory addressing block
`timescale 1ns/100ps
module cma_core_test;
    logic        sys_clk_i = 1'b0;
    logic        rst_i     = 1'b1;
    logic        start_i   = 1'b0;
    logic        form_ea_i = 1'b0;
    logic [1:0]  purpose_i = 2'h0;
    logic [15:0] first_scratch_pad_i = 16'h0000;
    logic [15:0] instr_i = 16'h0000;
    logic [14:0] instr_addr_i = 15'h0000;
    logic [15:0] acc_a_i, acc_b_i, read_data_o, d, ins;
    logic [14:0] mem_addr_o, ea_o, ea_s, a;
    logic        busy_o, done_o, is_instr_o, parity_err_o;
    logic        acc_hit_o, ea_valid_o, bad_addr_o;
    logic [31:0] rnd = 32'h0000_0020;
    int          n_errors = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          lat;
    cma_core #(.STACK_WORDS(4096), .NUM_STACKS(1)) dut
    (
        .sys_clk_i, .rst_i, .start_i, .purpose_i, .first_scratch_pad_i, .instr_i,
        .instr_addr_i, .form_ea_i, .acc_a_i, .acc_b_i, .mem_addr_o, .read_data_o,
        .busy_o, .done_o, .is_instr_o, .parity_err_o, .acc_hit_o, .ea_o,
        .ea_valid_o, .bad_addr_o
    );
    cma_proc_model prc
    (
        .sys_clk_i, .rst_i, .seed_i(16'h5A3C), .acc_a_o(acc_a_i), .acc_b_o(acc_b_i)
    );
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    always #5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            finish_test();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e)
        begin
            n_errors++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
        end
    endtask : chk
    // Preload a core word, with odd parity or deliberately broken parity
    task automatic put(input logic [14:0] ad, input logic [15:0] v, input logic ok);
        dut.core_mem[ad] = {ok ? ~^v : ^v, v};
    endtask : put
    // One read request, held for one clock edge, then a bounded wait for done
    task automatic rd(input logic [14:0] ad, input logic [1:0] p, input logic f,
                      input logic [15:0] i, input logic [14:0] ia);
        @(negedge sys_clk_i);
        first_scratch_pad_i = {1'b0, ad};
        purpose_i = p;
        form_ea_i = f;
        instr_i = i;
        instr_addr_i = ia;
        start_i = 1'b1;
        lat = 0;
        ea_s = 15'h7FFF;
        @(posedge sys_clk_i);
        #1;
        // A direct address pulses its result right at the take
        if (ea_valid_o === 1'b1)
            ea_s = ea_o;
        while (lat < 60 && done_o !== 1'b1)
        begin
            @(negedge sys_clk_i);
            start_i = 1'b0;
            @(posedge sys_clk_i);
            #1;
            lat++;
            if (ea_valid_o === 1'b1)
                ea_s = ea_o;
        end
    endtask : rd
    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        rst_i = 1'b0;
        // Random core reads with boundary addresses, each read twice
        for (int i = 0; i < 12; i++)
        begin
            rnd = lfsr(rnd);
            a = (i == 0) ? 15'h0002 : (i == 1) ? 15'h0FFF : 15'(2 + rnd[15:0] % 4094);
            d = rnd[31:16];
            put(a, d, 1'b1);
            for (int k = 0; k < 2; k++)
            begin
                rd(a, 2'(i % 3), 1'b0, 16'h0000, 15'h0000);
                chk(read_data_o, d);
                chk(mem_addr_o, a);
                chk(is_instr_o, i % 3 == 1);
                chk(parity_err_o, 0);
                chk(bad_addr_o, 0);
                chk(busy_o, 0);
                chk(lat, 5);
            end
        end
        // Broken parity is flagged, restore rewrites it good
        put(15'h0123, 16'h00F0, 1'b0);
        rd(15'h0123, 2'h2, 1'b0, 16'h0000, 15'h0000);
        chk(parity_err_o, 1);
        rd(15'h0123, 2'h2, 1'b0, 16'h0000, 15'h0000);
        chk(parity_err_o, 0);
        // Addresses 0 and 1 return the accumulators
        for (int k = 0; k < 2; k++)
        begin
            rd(15'(k), 2'h2, 1'b0, 16'h0000, 15'h0000);
            chk(read_data_o, k ? 16'hA5C3 : 16'h5A3C);
            chk(acc_hit_o, 1);
            chk(lat, 4);
        end
        // First word beyond a small stack
        rd(15'h1000, 2'h0, 1'b0, 16'h0000, 15'h0000);
        chk(bad_addr_o, 1);
        chk(read_data_o, 0);
        chk(acc_hit_o, 0);
        // Direct addressing, page zero then current page
        for (int k = 0; k < 2; k++)
        begin
            rnd = lfsr(rnd);
            ins = {1'b0, rnd[3:0], k[0], 10'(2 + rnd[9:4])};
            a = k ? {5'h03, ins[9:0]} : {5'h00, ins[9:0]};
            put(a, rnd[31:16], 1'b1);
            rd(15'h0000, 2'h2, 1'b1, ins, 15'h0C77);
            chk(ea_s, a);
            chk(mem_addr_o, a);
            chk(read_data_o, rnd[31:16]);
        end
        // Indirect chains of one, two and three pointers
        for (int h = 0; h < 3; h++)
        begin
            for (int j = 0; j <= h; j++)
                put(15'(16'h0200 + j), j < h ? {1'b1, 15'(16'h0201 + j)} : 16'h0ABC, 1'b1);
            put(15'h0ABC, 16'h1234, 1'b1);
            rd(15'h0000, 2'h2, 1'b1, 16'h8200, 15'h0000);
            chk(ea_s, 15'h0ABC);
            chk(lat, 5 + 4 * h);
        end
        finish_test();
    end
endmodule : cma_core_test
